// ===== rtl/standby_wake_source_config.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
module standby_wake_source_config
  import wake_pkg::*;
(
  // clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        sys_rst_i,
  // avalon-mm slave
  input  wire logic [wake_pkg::ADDR_W-1:0] address_i,
  input  wire logic                        read_i,
  input  wire logic                        write_i,
  input  wire logic [31:0]                 writedata_i,
  input  wire logic [3:0]                  byteenable_i,
  output logic [31:0]                      readdata_o,
  output logic                             waitrequest_o,
  // wake pins, asynchronous
  input  wire logic                        ext_wake_input_zero_i,
  input  wire logic                        ext_wake_input_one_i,
  input  wire logic                        ext_wake_input_two_i,
  input  wire logic                        ext_wake_input_three_i,
  // standby controller
  input  wire logic                        standby_i,
  output logic                             release_req_o,
  output logic [3:0]                       release_pending_o
);
  import wake_pkg::*;

  wake_src_if sif ();                 // link to the detector

  logic [3:0]      meta_reg;          // first synchroniser stage
  logic [3:0]      sync_reg;          // second synchroniser stage
  logic            ack_reg;           // bus answer phase
  logic            ack_next;
  logic [31:0]     rdata_reg;         // registered read data
  logic [31:0]     rdata_next;
  logic [3:0][2:0] sel_reg;           // release_level_select per source
  logic [3:0][2:0] sel_next;
  logic [3:0]      en_reg;            // release_source_enable per source
  logic [3:0]      en_next;
  logic [3:0][1:0] rec_reg;           // release_edge_record per source
  logic [3:0][1:0] rec_next;
  logic [3:0]      pend_reg;          // pending release request per source
  logic [3:0]      pend_next;
  logic            req;               // any bus request
  logic            wr_fire;           // write takes effect this edge
  logic            wr_mode;
  logic            wr_clear;

  // pins cross into mclk domain; only sync_reg is read by logic
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
    end
    else
    begin
      meta_reg <= {ext_wake_input_three_i, ext_wake_input_two_i,
                   ext_wake_input_one_i, ext_wake_input_zero_i};
      sync_reg <= meta_reg;
    end
  end

  // detector sees registered configuration
  assign sif.sel     = sel_reg;
  assign sif.en      = en_reg;
  assign sif.pin     = sync_reg;
  assign sif.standby = standby_i;

  wake_src_detect u_detect (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .sif       (sif)
  );

  // mode register image; record shows only in both-edges mode
  function automatic logic [31:0] mode_word(input logic [3:0][2:0] s,
                                            input logic [3:0]      e,
                                            input logic [3:0][1:0] r);
    logic [31:0] w;
    w = 32'h0000_0000;                                    // bits 7,15,23,31 and spare read 0
    for (int n = 0; n < SRC_N; n++)
    begin
      w[n*SRC_STRIDE+SEL_LSB +: 3] = s[n];                // see [RL8]
      w[n*SRC_STRIDE+REC_LSB +: 2] = (s[n] == SEL_BOTH) ? r[n] : REC_NONE; // see [RL4]
      w[n*SRC_STRIDE+EN_BIT]       = e[n];
    end
    return w;
  endfunction

  // bus handshake: one wait cycle, then answer
  assign req           = read_i | write_i;
  assign waitrequest_o = req & ~ack_reg;
  assign wr_fire       = write_i & ack_reg;
  assign wr_mode       = wr_fire & (address_i == OFS_MODE_A);
  assign wr_clear      = wr_fire & (address_i == OFS_CLEAR);
  assign readdata_o    = rdata_reg;

  // next bus phase and read data
  always_comb
  begin
    ack_next   = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (read_i & ~ack_reg)
    begin
      case (address_i)
        OFS_MODE_A: rdata_next = mode_word(sel_reg, en_reg, rec_reg); // see [RL9]
        OFS_STATUS:
        begin
          rdata_next           = {28'h000_0000, pend_reg};
          rdata_next[STBY_BIT] = standby_i;
        end
        default:    rdata_next = RD_UNMAPPED;             // clear word reads 0 too
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // configuration, record and pending state
  always_comb
  begin
    sel_next  = sel_reg;
    en_next   = en_reg;
    rec_next  = rec_reg;
    pend_next = pend_reg;
    for (int n = 0; n < SRC_N; n++)
    begin
      // one byte lane per source; record bits are read-only
      if (wr_mode && byteenable_i[n])
      begin
        sel_next[n] = writedata_i[n*SRC_STRIDE+SEL_LSB +: 3]; // see [RL8]
        en_next[n]  = writedata_i[n*SRC_STRIDE+EN_BIT];       // see [RL6] see [RL3]
      end
      // clearing a request also wipes its edge record
      if (wr_clear && writedata_i[n])
      begin
        pend_next[n] = 1'b0;
        rec_next[n]  = REC_NONE;                          // see [RL5]
      end
      // a hit after the clear wins, so no event is lost
      if (sif.hit[n])
      begin
        pend_next[n] = 1'b1;                              // see [RL10]
        if (sel_reg[n] == SEL_BOTH)
          rec_next[n] = rec_next[n] | sif.edge_seen[n];   // rise then fall gives 11, see [RL3]
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sel_reg  <= {SRC_N{SEL_RESET}};                     // see [RL9]
      en_reg   <= 4'h0;
      rec_reg  <= {SRC_N{REC_NONE}};
      pend_reg <= 4'h0;
    end
    else
    begin
      sel_reg  <= sel_next;
      en_reg   <= en_next;
      rec_reg  <= rec_next;
      pend_reg <= pend_next;
    end
  end

  // request to the standby controller stays up until software clears it
  assign release_req_o     = |pend_reg;
  assign release_pending_o = pend_reg;

  chk_pend_on_hit: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RL10]
    (sif.hit != 4'h0) |=> ((pend_reg & $past(sif.hit)) == $past(sif.hit)) && release_req_o)
    else $error("hit did not raise a pending request");
  chk_clear_wipes: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RL5]
    (wr_clear && writedata_i[0] && !sif.hit[0]) |=> (!pend_reg[0] && rec_reg[0] == REC_NONE))
    else $error("clear left request or record standing");
  chk_enable_blocks: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RL6]
    (sif.hit & ~en_reg) == 4'h0)
    else $error("disabled source raised a hit");
  chk_rec_hidden: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RL4]
    (read_i && !ack_reg && address_i == OFS_MODE_A && sel_reg[3] != SEL_BOTH)
      |=> readdata_o[27:26] == REC_NONE)
    else $error("record visible outside both-edges mode");
  chk_zero_bits: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RL9]
    (read_i && !ack_reg && address_i == OFS_MODE_A)
      |=> (readdata_o[31] | readdata_o[23] | readdata_o[15] | readdata_o[ZERO_BIT]) == 1'b0)
    else $error("fixed zero bit read as one");
  chk_rec_readonly: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RL3]
    (wr_mode && sif.hit == 4'h0) |=> $stable(rec_reg))
    else $error("bus write changed an edge record");
  chk_layout_src3: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RL8]
    (wr_mode && byteenable_i[3])
      |=> sel_reg[3] == $past(writedata_i[30:28]) && en_reg[3] == $past(writedata_i[24]))
    else $error("source 3 fields not at 30-28 and 24");
  chk_one_wait: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (req && waitrequest_o) |=> !waitrequest_o)
    else $error("waitrequest held more than one cycle");
endmodule

// ===== inc/wake_pkg.sv
// Function
// [RL1] selector codes pick low, high, fall, rise, both
// [RL2] software never writes selector codes 101-111
// [RL3] record reads 01 rise, 10 fall, 11 both
// [RL4] record meaningful only in both-edges mode
// [RL5] request clear also clears the edge record
// [RL6] enable 0 blocks release, 1 permits it
// [RL7] software sets selector before enable, separately
// [RL8] source fields repeat every eight bits downward
// [RL9] defined reset values, fixed zero and undefined bits
// [RL10] enabled hit in standby raises request, latches edge; the code latches the edge only in both-edges mode
package wake_pkg;
  localparam int          SRC_N      = 4;      // wake sources in this register
  localparam int          SRC_STRIDE = 8;      // bits between neighbouring sources
  localparam int          SEL_LSB    = 4;      // selector low bit inside a source byte
  localparam int          REC_LSB    = 2;      // edge record low bit inside a source byte
  localparam int          EN_BIT     = 0;      // enable bit inside a source byte
  localparam int          ZERO_BIT   = 7;      // always-zero bit inside a source byte
  localparam int          STBY_BIT   = 8;      // standby flag in status word
  // selector encodings
  localparam logic [2:0]  SEL_LOW    = 3'h0;
  localparam logic [2:0]  SEL_HIGH   = 3'h1;
  localparam logic [2:0]  SEL_FALL   = 3'h2;
  localparam logic [2:0]  SEL_RISE   = 3'h3;
  localparam logic [2:0]  SEL_BOTH   = 3'h4;
  localparam logic [2:0]  SEL_RESET  = 3'h2;
  // edge record encodings
  localparam logic [1:0]  REC_NONE   = 2'h0;
  localparam logic [1:0]  REC_RISE   = 2'h1;
  localparam logic [1:0]  REC_FALL   = 2'h2;
  localparam logic [1:0]  REC_BOTH   = 2'h3;
  // bus map, byte addresses
  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  OFS_MODE_A = 4'h0;
  localparam logic [3:0]  OFS_CLEAR  = 4'h4;
  localparam logic [3:0]  OFS_STATUS = 4'h8;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// ===== inc/wake_src_if.sv
`timescale 1ns/10ps
// carries selector, enable and detection results between config and detector
interface wake_src_if;
  logic [3:0][2:0] sel;        // per-source level selector
  logic [3:0]      en;         // per-source enable
  logic [3:0]      pin;        // synchronised pin levels
  logic            standby;    // device is in standby
  logic [3:0]      hit;        // release condition met this cycle
  logic [3:0][1:0] edge_seen;  // {fall, rise} seen this cycle
  modport cfg (output sel, en, pin, standby, input hit, edge_seen);
  modport det (input sel, en, pin, standby, output hit, edge_seen);
endinterface

// ===== rtl/wake_src_detect.sv
`timescale 1ns/10ps
module wake_src_detect
  import wake_pkg::*;
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // configuration side
  wake_src_if.det   sif
);
  logic [3:0] prev_reg;   // pin level one cycle ago
  logic [3:0] prev_next;

  // edge history: previous level only
  always_comb
  begin
    prev_next = sif.pin;
  end

  // reset to low, so a pin that is high at release looks like a rising edge once
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      prev_reg <= 4'h0;
    else
      prev_reg <= prev_next;
  end

  // condition per source, gated by enable and standby
  always_comb
  begin
    for (int n = 0; n < SRC_N; n++)
    begin
      logic rise;
      logic fall;
      logic cond;
      cond = 1'b0;                                          // defined on every path
      rise = sif.pin[n] & ~prev_reg[n];
      fall = ~sif.pin[n] & prev_reg[n];
      case (sif.sel[n])                                     // see [RL1]
        SEL_LOW:  cond = ~sif.pin[n];
        SEL_HIGH: cond = sif.pin[n];
        SEL_FALL: cond = fall;
        SEL_RISE: cond = rise;
        SEL_BOTH: cond = rise | fall;
        default:  cond = 1'b0;                              // forbidden codes never fire
      endcase
      sif.hit[n]       = cond & sif.en[n] & sif.standby;   // see [RL6] see [RL10]
      sif.edge_seen[n] = {fall, rise};
    end
  end

  chk_level_low_fires: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RL1]
    (sif.en[0] && sif.standby && sif.sel[0] == SEL_LOW && !sif.pin[0]) |-> sif.hit[0])
    else $error("low level on enabled source 0 did not fire");
  chk_bad_code_silent: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RL2]
    (sif.sel[1] > SEL_BOTH) |-> !sif.hit[1])
    else $error("forbidden selector code fired a release");
endmodule

// ===== test/wake_pin_model.sv
`timescale 1ns/10ps
// far side: external wake pins, levels follow the bench one clock later
module wake_pin_model
(
  // clock
  input  wire logic       mclk_i,
  // wanted pin levels
  input  wire logic [3:0] level_i,
  // pins toward the block
  output logic      [3:0] pin_o
);
  // registered so a pin never moves in the block's own sampling step
  always_ff @(posedge mclk_i)
  begin
    pin_o <= level_i;
  end
endmodule

// ===== test/standby_wake_source_config_test.sv
`timescale 1ns/10ps
module standby_wake_source_config_test;
  import wake_pkg::*;
  logic            mclk_i, sys_rst_i, read_i, write_i, standby_i;
  logic [3:0]      address_i, byteenable_i, lvl, pins, pend;
  logic [31:0]     writedata_i, readdata_o, q, wd;
  logic            waitrequest_o, release_req_o;
  logic [3:0][2:0] cur_sel;   // bench copy of selectors
  logic [3:0]      cur_en;    // bench copy of enables
  logic [2:0]      code;
  logic [1:0]      rec;
  logic            en, idle;
  int              err_total, n_compared, cyc, s;
  int              seed = 32'h7828;
  // block under test, every input driven by the bench or the pin model
  standby_wake_source_config DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .ext_wake_input_zero_i(pins[0]),
    .ext_wake_input_one_i(pins[1]), .ext_wake_input_two_i(pins[2]),
    .ext_wake_input_three_i(pins[3]), .standby_i(standby_i),
    .release_req_o(release_req_o), .release_pending_o(pend));
  wake_pin_model PINS (.mclk_i(mclk_i), .level_i(lvl), .pin_o(pins));
  // clock at 100 MHz
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // hang guard, far above the roughly 380 cycles the run needs
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // one avalon cycle; values read right after the edge are those the edge sampled;
  // waits as long as the slave asks, only the hang guard ends a stuck wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    @(posedge mclk_i);
    read_i       <= ~wr;
    write_i      <= wr;
    address_i    <= a;
    writedata_i  <= d;
    byteenable_i <= be;
    do
    begin
      @(posedge mclk_i);
    end
    while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask
  // expected mode word: record shows only under the both-edges code
  function automatic logic [31:0] mword(input logic [1:0] r, input int src);
    logic [31:0] w;
    for (int n = 0; n < SRC_N; n++)
      w[n*8+:8] = {1'b0, cur_sel[n], (cur_sel[n] == SEL_BOTH && n == src) ? r : 2'h0,
                   1'b0, cur_en[n]};
    return w;
  endfunction
  // main sequence
  initial
  begin
    {read_i, write_i, standby_i, address_i, writedata_i, byteenable_i} = '0;
    sys_rst_i = 1'b1;
    lvl       = 4'h0;
    tick(12);
    sys_rst_i <= 1'b0;
    cur_sel = {4{SEL_RESET}};
    cur_en  = 4'h0;
    bus(1'b0, OFS_MODE_A, 32'h0, 4'hf, q);
    chk("reset word", q, mword(2'h0, 0));
    bus(1'b0, 4'hc, 32'h0, 4'hf, q);
    chk("unmapped", q, RD_UNMAPPED);
    // random lanes and fields; record and fixed bits in the data must not stick
    // even passes change selectors only, odd passes enables only
    for (int i = 0; i < 6; i++)
    begin
      wd = $random(seed);
      for (int n = 0; n < SRC_N; n++)
        if (i % 2 == 0)
        begin
          wd[n*8+4+:3] = 3'($unsigned($random(seed)) % 5);
          wd[n*8]      = cur_en[n];
        end
        else
          wd[n*8+4+:3] = cur_sel[n];
      s = $random(seed);
      bus(1'b1, OFS_MODE_A, wd, s[3:0], q);
      for (int n = 0; n < SRC_N; n++)
        if (s[n])
          {cur_sel[n], cur_en[n]} = {wd[n*8+4+:3], wd[n*8]};
      bus(1'b0, OFS_MODE_A, 32'h0, 4'hf, q);
      chk("lane write", q, mword(2'h0, 0));
    end
    // enables off first, selectors back to reset in a later write
    cur_en = 4'h0;
    bus(1'b1, OFS_MODE_A, mword(2'h0, 0), 4'hf, q);
    cur_sel = {4{SEL_RESET}};
    bus(1'b1, OFS_MODE_A, mword(2'h0, 0), 4'hf, q);
    // each of the selector codes 000-100; step 5 is both edges with the source left disabled
    for (int m = 0; m < 6; m++)
    begin
      s    = $unsigned($random(seed)) % 4;
      code = (m == 5) ? SEL_BOTH : 3'(m);
      en   = (m != 5);
      idle = (code == SEL_LOW || code == SEL_FALL);
      lvl  <= {4{idle}};
      tick(6);
      bus(1'b1, OFS_CLEAR, 32'hf, 4'hf, q);
      cur_sel[s] = code;
      bus(1'b1, OFS_MODE_A, mword(2'h0, s), 4'hf, q);
      cur_en[s] = en;
      bus(1'b1, OFS_MODE_A, mword(2'h0, s), 4'hf, q);
      standby_i <= 1'b1;
      tick(6);
      bus(1'b0, OFS_STATUS, 32'h0, 4'hf, q);
      chk("quiet status", q, 32'h100);
      lvl[s] <= ~idle;
      tick(6);
      bus(1'b0, OFS_STATUS, 32'h0, 4'hf, q);
      chk("hit status", q, 32'h100 | (32'(en) << s));
      chk("release req", 32'(release_req_o), 32'(en));
      chk("pending pins", 32'(pend), 32'(en) << s);
      rec = en ? REC_RISE : REC_NONE;
      if (code == SEL_BOTH)
      begin
        lvl[s] <= idle;
        tick(6);
        rec = en ? REC_BOTH : REC_NONE;
      end
      bus(1'b0, OFS_MODE_A, 32'h0, 4'hf, q);
      chk("edge record", q, mword(rec, s));
      standby_i <= 1'b0;
      bus(1'b1, OFS_CLEAR, 32'h1 << s, 4'h0, q);
      bus(1'b0, OFS_STATUS, 32'h0, 4'hf, q);
      chk("cleared", q, 32'h0);
      bus(1'b0, OFS_MODE_A, 32'h0, 4'hf, q);
      chk("record cleared", q, mword(2'h0, s));
      // enable off first, selector back to reset in a later write
      cur_en[s] = 1'b0;
      bus(1'b1, OFS_MODE_A, mword(2'h0, s), 4'hf, q);
      cur_sel[s] = SEL_RESET;
      bus(1'b1, OFS_MODE_A, mword(2'h0, s), 4'hf, q);
    end
    bus(1'b0, OFS_CLEAR, 32'h0, 4'hf, q);
    chk("clear word", q, 32'h0);
    final_report();
  end
endmodule
